/* hw/gdfp_top.sv */
// Fault supervision, overcurrent response and register slave of the gate driver
// Behaviour
// - Supply or drain supply low: all FETs off, pump off, fault output low.
// - Supply low latches flags; driving resumes when gone; flag held until clear.
// - Supply low may also raise gate-supply low; both flags may be set.
// - Pump or low rail low: FETs off, fault low, flags latched, pump kept.
// - Gate-supply low ends: drive resumes; its flag held until clear.
// - Gate check off bit suppresses gate-supply protection; pin variant always protects.
// - Drain-source event needs enabled FET over trip longer than filter time.
// - Pin variant: 4 us filter, 8 ms retry; tied trip pin disables it.
// - Register variant: programmable trip, filter; mode latch, retry, report, off.
// - Latched mode: FETs off, fault low, flags; recover on clear after condition.
// - Retry mode drain-source: off, fault low, flags held until retry ends.
// - Retry mode shunt: same shutdown and hold until retry time ends.
// - Report mode: drivers run, fault low, flags latched until clear.
// - Per-cycle mode default: PWM rising edge clears overcurrent; register may disable.
// - Scope 0 shuts own half-bridge; scope 1 shuts all three.
// - Shunt event when sense input over trip longer than filter time.
// - Pin variant shunt: fixed level, 4 us filter, 8 ms retry; the shunt level output still follows the configuration register.
// - Shunt check off bit gives no action on shunt events.
// - Clear by clear-faults bit write or enable reset pulse.
//
// The AXI4-Lite slave port and the placing of the registers were decided locally.
`timescale 1ns/10ps

// Deglitch counter that fires once when a condition outlasts its length
module gdfp_filter
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Condition and length
  input wire logic i_cond,
  input wire logic [15:0] i_len,
  // Event pulse
  output logic o_event
);
  logic [15:0] cnt_r;
  logic [15:0] cnt_nxt;
  logic hit_r;
  logic hit_nxt;

  // Count while the condition holds, restart when it drops
  always_comb
  begin
    cnt_nxt = cnt_r;
    if (!i_cond)
      cnt_nxt = 16'h0000;
    else if (cnt_r < i_len)
      cnt_nxt = cnt_r + 16'h0001;
    hit_nxt = i_cond && (cnt_r >= i_len);
    o_event = hit_nxt && !hit_r;
  end

  // Counter registers
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      cnt_r <= 16'h0000;
      hit_r <= 1'b0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      hit_r <= hit_nxt;
    end
  end
endmodule : gdfp_filter

module gdfp_top
#(
  parameter int unsigned RETRY_CYCLES = gdfp_pkg::RETRY_CYC
)
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // AXI4-Lite write channels
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [7:0] i_awaddr,
  input wire logic i_wvalid,
  output logic o_wready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  output logic o_bvalid,
  input wire logic i_bready,
  output logic [1:0] o_bresp,
  // AXI4-Lite read channels
  input wire logic i_arvalid,
  output logic o_arready,
  input wire logic [7:0] i_araddr,
  output logic o_rvalid,
  input wire logic i_rready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  // Comparator results, asynchronous
  input wire logic i_motor_supply_low,
  input wire logic i_drain_sense_supply_low,
  input wire logic i_pump_rail_low,
  input wire logic i_low_gate_rail_low,
  input wire logic [5:0] i_ds_over,
  input wire logic [2:0] i_shunt_over,
  // Controller pins and straps, asynchronous
  input wire logic [5:0] i_pwm,
  input wire logic i_enable,
  input wire logic i_pin_cfg,
  input wire logic i_ds_trip_tied,
  // Driver and fault outputs
  output logic [5:0] o_gate_allow,
  output logic o_pump_on,
  output logic o_fault_out_low,
  output logic [3:0] o_drain_source_trip_level,
  output logic [1:0] o_shunt_trip_level
);
  import gdfp_pkg::*;

  localparam logic [20:0] RETRY_LAST = 21'(RETRY_CYCLES - 1);

  logic [SYNC_W-1:0] sync1_r;
  logic [SYNC_W-1:0] sync2_r;
  logic uv_s, gr_s, pin_s, tied_s, en_s;
  logic [5:0] ds_s, pwm_s;
  logic [2:0] sh_s;
  logic [6:0] ctrl_r, ctrl_nxt;
  logic [21:0] cfg_r, cfg_nxt;
  logic aw_got_r, aw_got_nxt, w_got_r, w_got_nxt, bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
  logic [7:0] aw_addr_r, aw_addr_nxt;
  logic [31:0] w_data_r, w_data_nxt, rdata_r, rdata_nxt, status;
  logic [3:0] w_strb_r, w_strb_nxt;
  logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic wr_do, clear_cmd, en_prev_r, pwm_rise;
  logic [5:0] pwm_prev_r;
  logic [1:0] mode_eff;
  logic cbc_eff, scope_eff, gchk_eff, ds_en, sh_en, gate_supply_low_flag;
  logic [15:0] filt_len;
  logic [8:0] cond, ev, oc_r, oc_nxt;
  logic [20:0] retry_r, retry_nxt;
  logic retry_done;
  logic sup_flag_r, sup_flag_nxt, gate_flag_r, gate_flag_nxt;
  logic [2:0] bridge_fault, half_off;
  logic [5:0] allow_r, allow_nxt;
  logic pump_r, pump_nxt, fault_low_r, fault_low_nxt;

  // Two-stage synchroniser for every pin input
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      // Enable idles high, so no false clear edge follows reset
      sync1_r <= 22'h000010;
      sync2_r <= 22'h000010;
      en_prev_r <= 1'b1;
      pwm_prev_r <= 6'h00;
    end
    else
    begin
      sync1_r <= {i_motor_supply_low | i_drain_sense_supply_low, i_pump_rail_low | i_low_gate_rail_low,
                  i_ds_over, i_shunt_over, i_pwm, i_enable, i_pin_cfg, i_ds_trip_tied, 1'b0, 1'b0};
      sync2_r <= sync1_r;
      en_prev_r <= en_s;
      pwm_prev_r <= pwm_s;
    end
  end

  // Synchronised pin fields
  assign uv_s = sync2_r[21];
  assign gr_s = sync2_r[20];
  assign ds_s = sync2_r[19:14];
  assign sh_s = sync2_r[13:11];
  assign pwm_s = sync2_r[10:5];
  assign en_s = sync2_r[4];
  assign pin_s = sync2_r[3];
  assign tied_s = sync2_r[2];

  // AXI handshakes and register writes
  assign o_awready = !aw_got_r && !bvalid_r;
  assign o_wready = !w_got_r && !bvalid_r;
  assign o_arready = !rvalid_r;
  assign wr_do = aw_got_r && w_got_r && !bvalid_r;

  // Next state of the bus slave and the writable registers
  always_comb
  begin
    aw_got_nxt = aw_got_r;
    aw_addr_nxt = aw_addr_r;
    w_got_nxt = w_got_r;
    w_data_nxt = w_data_r;
    w_strb_nxt = w_strb_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    rvalid_nxt = rvalid_r;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    ctrl_nxt = ctrl_r;
    ctrl_nxt[CT_CLEAR] = 1'b0;
    cfg_nxt = cfg_r;
    clear_cmd = en_s && !en_prev_r;
    if (i_awvalid && o_awready)
    begin
      aw_got_nxt = 1'b1;
      aw_addr_nxt = i_awaddr;
    end
    if (i_wvalid && o_wready)
    begin
      w_got_nxt = 1'b1;
      w_data_nxt = i_wdata;
      w_strb_nxt = i_wstrb;
    end
    if (bvalid_r && i_bready)
      bvalid_nxt = 1'b0;
    if (wr_do)
    begin
      aw_got_nxt = 1'b0;
      w_got_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = RESP_OKAY;
      if (aw_addr_r[7:2] == ADDR_CTRL[7:2])
      begin
        if (w_strb_r[0])
          ctrl_nxt = {w_data_r[6:1], 1'b0}; // Clear bit reads back as 0
        clear_cmd = clear_cmd || (w_strb_r[0] && w_data_r[CT_CLEAR]);
      end
      else if (aw_addr_r[7:2] == ADDR_CFG[7:2])
      begin
        if (w_strb_r[0])
          cfg_nxt[7:0] = w_data_r[7:0];
        if (w_strb_r[1])
          cfg_nxt[15:8] = w_data_r[15:8];
        if (w_strb_r[2])
          cfg_nxt[21:16] = w_data_r[21:16];
      end
      else if (aw_addr_r[7:2] != ADDR_STATUS[7:2])
        bresp_nxt = RESP_SLVERR;
    end
    if (rvalid_r && i_rready)
      rvalid_nxt = 1'b0;
    if (i_arvalid && o_arready)
    begin
      rvalid_nxt = 1'b1;
      rresp_nxt = RESP_OKAY;
      rdata_nxt = 32'h00000000;
      case (i_araddr[7:2])
        ADDR_STATUS[7:2]: rdata_nxt = status;
        ADDR_CTRL[7:2]: rdata_nxt = {25'h0000000, ctrl_r};
        ADDR_CFG[7:2]: rdata_nxt = {10'h000, cfg_r};
        default: rresp_nxt = RESP_SLVERR;
      endcase
    end
  end

  // Bus slave registers
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      aw_got_r <= 1'b0;
      aw_addr_r <= 8'h00;
      w_got_r <= 1'b0;
      w_data_r <= 32'h00000000;
      w_strb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= 2'h0;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h00000000;
      rresp_r <= 2'h0;
      ctrl_r <= CTRL_RESET;
      cfg_r <= CFG_RESET;
    end
    else
    begin
      aw_got_r <= aw_got_nxt;
      aw_addr_r <= aw_addr_nxt;
      w_got_r <= w_got_nxt;
      w_data_r <= w_data_nxt;
      w_strb_r <= w_strb_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      rvalid_r <= rvalid_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
      ctrl_r <= ctrl_nxt;
      cfg_r <= cfg_nxt;
    end
  end

  assign o_bvalid = bvalid_r;
  assign o_bresp = bresp_r;
  assign o_rvalid = rvalid_r;
  assign o_rdata = rdata_r;
  assign o_rresp = rresp_r;
  assign o_drain_source_trip_level = cfg_r[CF_DS_LVL +: 4];
  assign o_shunt_trip_level = cfg_r[CF_SH_LVL +: 2];

  // Effective settings: pin variant overrides the registers
  assign mode_eff = pin_s ? MODE_RETRY : ctrl_r[CT_MODE +: 2];
  assign cbc_eff = pin_s || ctrl_r[CT_CBC];
  assign scope_eff = !pin_s && ctrl_r[CT_SCOPE];
  assign gchk_eff = pin_s || !ctrl_r[CT_GATE_OFF];
  assign ds_en = pin_s ? !tied_s : (mode_eff != MODE_OFF);
  assign sh_en = pin_s || ((mode_eff != MODE_OFF) && !ctrl_r[CT_SHUNT_OFF]);
  assign filt_len = pin_s ? DEGLITCH_CYC : cfg_r[CF_FILT +: 16];
  assign gate_supply_low_flag = gr_s && gchk_eff;
  assign pwm_rise = |(pwm_s & ~pwm_prev_r);

  // Overcurrent conditions: drain-source on enabled FETs, shunt per sense input
  assign cond = {sh_s & {3{sh_en}}, ds_s & pwm_s & allow_r & {6{ds_en}}};

  // One deglitch filter per monitored overcurrent source
  for (genvar g = 0; g < 9; g++)
  begin : g_filt
    gdfp_filter u_filt
    (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .i_cond(cond[g]),
      .i_len(filt_len),
      .o_event(ev[g])
    );
  end

  // Fault flags, retry timer and gate permissions
  always_comb
  begin
    retry_done = (mode_eff == MODE_RETRY) && (|oc_r) && (retry_r == RETRY_LAST);
    retry_nxt = 21'h000000;
    if ((mode_eff == MODE_RETRY) && (|oc_r) && !retry_done && !(|ev))
      retry_nxt = retry_r + 21'h000001;
    oc_nxt = oc_r;
    if (retry_done)
      oc_nxt = 9'h000;
    if (clear_cmd && (mode_eff != MODE_RETRY))
      oc_nxt = oc_nxt & {sh_s, ds_s};
    if (cbc_eff && pwm_rise)
      oc_nxt = 9'h000;
    oc_nxt = oc_nxt | ev;
    sup_flag_nxt = (sup_flag_r && !clear_cmd) || uv_s;
    gate_flag_nxt = (gate_flag_r && !clear_cmd) || gate_supply_low_flag;
    for (int h = 0; h < 3; h++)
      bridge_fault[h] = oc_r[2*h] || oc_r[2*h+1] || oc_r[6+h];
    if ((mode_eff != MODE_LATCH) && (mode_eff != MODE_RETRY))
      bridge_fault = 3'h0;
    half_off = scope_eff ? {3{|bridge_fault}} : bridge_fault;
    for (int h = 0; h < 3; h++)
      allow_nxt[2*h +: 2] = {2{!uv_s && !gate_supply_low_flag && !half_off[h]}};
    pump_nxt = !uv_s;
    fault_low_nxt = !(uv_s || gate_supply_low_flag || (|oc_r));
  end

  // Fault registers
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      oc_r <= 9'h000;
      retry_r <= 21'h000000;
      sup_flag_r <= 1'b0;
      gate_flag_r <= 1'b0;
      allow_r <= 6'h00;
      pump_r <= 1'b0;
      fault_low_r <= 1'b1;
    end
    else
    begin
      oc_r <= oc_nxt;
      retry_r <= retry_nxt;
      sup_flag_r <= sup_flag_nxt;
      gate_flag_r <= gate_flag_nxt;
      allow_r <= allow_nxt;
      pump_r <= pump_nxt;
      fault_low_r <= fault_low_nxt;
    end
  end

  // Status word seen by software
  assign status = {18'h00000, oc_r[8:6], oc_r[5:0], |oc_r[8:6], |oc_r[5:0], gate_flag_r, sup_flag_r,
                   sup_flag_r || gate_flag_r || (|oc_r) || !fault_low_r};
  assign o_gate_allow = allow_r;
  assign o_pump_on = pump_r;
  assign o_fault_out_low = fault_low_r;

  // Checks on the protection behaviour
  a_uv_shut_all: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    uv_s |=> (o_gate_allow == 6'h00) && !o_pump_on && !o_fault_out_low)
    else $error("supply low did not shut down");
  a_uv_flag_hold: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    sup_flag_r && !clear_cmd |=> sup_flag_r)
    else $error("supply low flag lost without clear");
  a_both_flags: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    uv_s && gate_supply_low_flag |=> sup_flag_r && gate_flag_r)
    else $error("both supply flags not set");
  a_gate_supply_low_flag_pump_on: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    gate_supply_low_flag && !uv_s |=> o_pump_on && (o_gate_allow == 6'h00) && gate_flag_r)
    else $error("gate supply low response wrong");
  a_gchk_ignored: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    !pin_s && ctrl_r[CT_GATE_OFF] && !uv_s && (oc_r == 9'h000) |=> o_fault_out_low)
    else $error("disabled gate supply check still faults");
  a_event_latch: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (|ev) |=> (((oc_r & $past(ev)) == $past(ev)) ##1 !o_fault_out_low))
    else $error("overcurrent event not latched");
  a_retry_hold: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (mode_eff == MODE_RETRY) && (|oc_r) && !retry_done && !(cbc_eff && pwm_rise) |=> (|oc_r))
    else $error("retry flags dropped early");
  a_report_runs: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (mode_eff == MODE_REPORT) && !uv_s && !gate_supply_low_flag && (|oc_r) |=> (o_gate_allow == 6'h3F) && !o_fault_out_low)
    else $error("report mode stopped the drivers");
  a_cbc_clear: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    cbc_eff && pwm_rise && !(|ev) |=> (oc_r == 9'h000))
    else $error("pwm edge did not clear overcurrent");
  a_scope_all: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    scope_eff && (mode_eff == MODE_LATCH) && (|oc_r) |=> (o_gate_allow == 6'h00))
    else $error("linked scope did not stop all bridges");
  a_shunt_off: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    !pin_s && ctrl_r[CT_SHUNT_OFF] && $past(!pin_s && ctrl_r[CT_SHUNT_OFF]) |-> (ev[8:6] == 3'h0))
    else $error("shunt event while shunt check off");
endmodule : gdfp_top

/* include/gdfp_pkg.sv */
// Package of constants for the gate driver fault protection block
package gdfp_pkg;
  // Register byte addresses
  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_CTRL = 8'h04;
  localparam logic [7:0] ADDR_CFG = 8'h08;
  // Status field positions
  localparam int ST_FAULT = 0;
  localparam int ST_SUPPLY = 1;
  localparam int ST_GATE = 2;
  localparam int ST_DS = 3;
  localparam int ST_SHUNT = 4;
  localparam int ST_DS_FET = 5;
  localparam int ST_SENSE = 11;
  // Control field positions
  localparam int CT_CLEAR = 0;
  localparam int CT_GATE_OFF = 1;
  localparam int CT_MODE = 2;
  localparam int CT_SHUNT_OFF = 4;
  localparam int CT_CBC = 5;
  localparam int CT_SCOPE = 6;
  localparam logic [6:0] CTRL_RESET = 7'h20;
  // Configuration field positions and reset value
  localparam int CF_FILT = 0;
  localparam int CF_DS_LVL = 16;
  localparam int CF_SH_LVL = 20;
  localparam logic [21:0] CFG_RESET = 22'h0003E8;
  // Overcurrent action codes
  localparam logic [1:0] MODE_LATCH = 2'h0;
  localparam logic [1:0] MODE_RETRY = 2'h1;
  localparam logic [1:0] MODE_REPORT = 2'h2;
  localparam logic [1:0] MODE_OFF = 2'h3;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Timing
  localparam int CLK_MHZ = 250;
  localparam int DEGLITCH_NS = 4000;
  localparam logic [15:0] DEGLITCH_CYC = 16'((DEGLITCH_NS * CLK_MHZ) / 1000);
  localparam int RETRY_MS = 8;
  localparam int RETRY_CYC = RETRY_MS * CLK_MHZ * 1000;
  // Synchroniser vector layout
  localparam int SYNC_W = 22;
endpackage : gdfp_pkg

/* testbench/gdfp_ctrl_model.sv */
// Motor controller model driving the PWM inputs and the enable pin
`timescale 1ns/10ps

module gdfp_ctrl_model
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Bench commands
  input wire logic [5:0] i_pwm_cmd,
  input wire logic i_clear_req,
  input wire logic i_report_mode,
  // Device side
  input wire logic i_fault_out_low,
  output logic [5:0] o_pwm,
  output logic o_enable
);
  int low_cnt;

  // Stops PWM itself on a reported fault, pulses enable low to clear
  always @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_pwm <= 6'h00;
      o_enable <= 1'b1;
      low_cnt <= 0;
    end
    else
    begin
      o_pwm <= (i_report_mode && !i_fault_out_low) ? 6'h00 : i_pwm_cmd;
      if (i_clear_req)
        low_cnt <= 4;
      else if (low_cnt > 0)
        low_cnt <= low_cnt - 1;
      o_enable <= (low_cnt == 0);
    end
  end
endmodule : gdfp_ctrl_model

/* testbench/gdfp_top_tb_top.sv */
// Self-checking bench of the gate driver fault protection block
`timescale 1ns/10ps

module gdfp_top_tb_top;
  import gdfp_pkg::*;
  localparam int RETRY = 50;
  localparam logic [31:0] DS_ST = 32'h29;
  localparam logic [31:0] SH_ST = 32'h1011;
  localparam logic [3:0] UV_TAB [5] = '{4'h5, 4'h2, 4'h4, 4'h8, 4'h8};
  localparam logic [7:0] PIN_TAB [5] = '{8'h00, 8'h00, 8'h40, 8'h40, 8'hFF};
  localparam logic [31:0] ST_TAB [5] = '{32'h7, 32'h3, 32'h5, 32'h5, 32'h0};
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awready, wready, bvalid, arready, rvalid, pump_on, fault_low, enable;
  logic [1:0] bresp, rresp, sh_lvl;
  logic [31:0] rdata;
  logic [3:0] uv = 4'h0;
  logic [3:0] ds_lvl;
  logic [5:0] ds_over = 6'h00;
  logic [2:0] shunt_over = 3'h0;
  logic [5:0] pwm_cmd = 6'h3F;
  logic clear_req = 1'b0;
  logic report_mode = 1'b0;
  logic [5:0] pwm, gate_allow;
  logic [15:0] rnd;
  int n_fail = 0;
  int total_checks = 0;
  int cyc = 0;
  int modes [$] = '{0, 1, 2, 3};

  // Clock and timeout
  always #2 clk = ~clk;
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_fail++;
      test_done();
    end
  end

  gdfp_top #(.RETRY_CYCLES(RETRY)) dut (.i_clk(clk), .i_rst_n(rst_n), .i_awvalid(awvalid),
    .o_awready(awready), .i_awaddr(awaddr), .i_wvalid(wvalid), .o_wready(wready), .i_wdata(wdata),
    .i_wstrb(4'hF), .o_bvalid(bvalid), .i_bready(bready), .o_bresp(bresp), .i_arvalid(arvalid),
    .o_arready(arready), .i_araddr(araddr), .o_rvalid(rvalid), .i_rready(rready), .o_rdata(rdata),
    .o_rresp(rresp), .i_motor_supply_low(uv[0]), .i_drain_sense_supply_low(uv[1]),
    .i_pump_rail_low(uv[2]), .i_low_gate_rail_low(uv[3]), .i_ds_over(ds_over),
    .i_shunt_over(shunt_over), .i_pwm(pwm), .i_enable(enable), .i_pin_cfg(1'b0),
    .i_ds_trip_tied(1'b0), .o_gate_allow(gate_allow), .o_pump_on(pump_on),
    .o_fault_out_low(fault_low), .o_drain_source_trip_level(ds_lvl), .o_shunt_trip_level(sh_lvl));

  gdfp_ctrl_model ctrl (.i_clk(clk), .i_rst_n(rst_n), .i_pwm_cmd(pwm_cmd), .i_clear_req(clear_req),
    .i_report_mode(report_mode), .i_fault_out_low(fault_low), .o_pwm(pwm), .o_enable(enable));

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr

  // Expected {fault_out_low, pump, gate_allow} for an overcurrent in bridge br
  function automatic logic [7:0] exp_pins(input int m, input int sc, input int br);
    logic [5:0] al;
    al = 6'h3F;
    if (m < 2)
      al = (sc != 0) ? 6'h00 : (al & ~(6'h03 << (2 * br)));
    return {(m == 3), 1'b1, al};
  endfunction : exp_pins

  task automatic chk_reg(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_reg

  task automatic chk_pin(input logic [7:0] e);
    @(negedge clk);
    total_checks++;
    if ({fault_low, pump_on, gate_allow} !== e)
    begin
      n_fail++;
      $display("Error pins expected %h seen %h", e, {fault_low, pump_on, gate_allow});
    end
    @(posedge clk);
  endtask : chk_pin

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask : idle

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    logic aw_hs, w_hs, done;
    logic [1:0] got;
    n = 0;
    done = 1'b0;
    got = 2'h0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      // Look at the settled handshakes before the edge that takes them
      @(negedge clk);
      aw_hs = awvalid && awready;
      w_hs = wvalid && wready;
      if (bvalid)
      begin
        done = 1'b1;
        got = bresp;
      end
      @(posedge clk);
      n++;
      if (aw_hs)
        awvalid <= 1'b0;
      if (w_hs)
        wvalid <= 1'b0;
    end
    while (!done && n < 100);
    bready <= 1'b0;
    if (n >= 100)
      n_fail++;
    chk_reg("bresp", {30'h0, er}, {30'h0, got});
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    logic ar_hs, done;
    logic [1:0] got_resp;
    logic [31:0] got_data;
    n = 0;
    done = 1'b0;
    got_resp = 2'h0;
    got_data = 32'h0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      // Take the answer while it stands, before the accepting edge
      @(negedge clk);
      ar_hs = arvalid && arready;
      if (rvalid)
      begin
        done = 1'b1;
        got_resp = rresp;
        got_data = rdata;
      end
      @(posedge clk);
      n++;
      if (ar_hs)
        arvalid <= 1'b0;
    end
    while (!done && n < 100);
    rready <= 1'b0;
    if (n >= 100)
      n_fail++;
    chk_reg("rresp", {30'h0, er}, {30'h0, got_resp});
    chk_reg("rdata", ed, got_data);
  endtask : axi_rd

  task automatic en_pulse();
    clear_req <= 1'b1;
    @(posedge clk);
    clear_req <= 1'b0;
    idle(20);
  endtask : en_pulse

  task automatic test_done();
    $display("Checks %0d, errors %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : test_done

  // Main sequence
  initial
  begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    axi_rd(ADDR_CTRL, 32'(CTRL_RESET), RESP_OKAY);
    axi_rd(ADDR_CFG, 32'(CFG_RESET), RESP_OKAY);
    axi_rd(ADDR_STATUS, 32'h0, RESP_OKAY);
    axi_wr(8'h0C, 32'hFFFFFFFF, RESP_SLVERR);
    axi_rd(8'h0C, 32'h0, RESP_SLVERR);
    rnd = 16'd19947;
    repeat (3)
    begin
      rnd = lfsr(rnd);
      axi_wr(ADDR_CFG, {10'h000, rnd[5:0], 16'h0004}, RESP_OKAY);
      axi_rd(ADDR_CFG, {10'h000, rnd[5:0], 16'h0004}, RESP_OKAY);
      chk_reg("trip_levels", {26'h0, rnd[5:0]}, {26'h0, sh_lvl, ds_lvl});
    end
    // Every overcurrent action on a drain-source event
    foreach (modes[i])
    begin
      report_mode <= (modes[i] == 2);
      axi_wr(ADDR_CTRL, 32'(modes[i]) << CT_MODE, RESP_OKAY);
      ds_over <= 6'h01;
      idle(20);
      chk_pin(exp_pins(modes[i], 0, 0));
      axi_rd(ADDR_STATUS, (modes[i] == 3) ? 32'h0 : DS_ST, RESP_OKAY);
      ds_over <= 6'h00;
      idle(5);
      if (modes[i] == 1)
        idle(RETRY + 10);
      else
        axi_wr(ADDR_CTRL, (32'(modes[i]) << CT_MODE) | 32'h1, RESP_OKAY);
      idle(8);
      chk_pin(exp_pins(3, 0, 0));
      axi_rd(ADDR_STATUS, 32'h0, RESP_OKAY);
    end
    report_mode <= 1'b0;
    // Linked scope, cleared by an enable pulse
    axi_wr(ADDR_CTRL, 32'h1 << CT_SCOPE, RESP_OKAY);
    ds_over <= 6'h10;
    idle(20);
    chk_pin(exp_pins(0, 1, 2));
    ds_over <= 6'h00;
    en_pulse();
    axi_rd(ADDR_STATUS, 32'h0, RESP_OKAY);
    // Per-cycle clearing by a new PWM rising edge
    axi_wr(ADDR_CTRL, 32'h1 << CT_CBC, RESP_OKAY);
    ds_over <= 6'h04;
    idle(20);
    chk_pin(exp_pins(0, 0, 1));
    ds_over <= 6'h00;
    pwm_cmd <= 6'h00;
    idle(4);
    pwm_cmd <= 6'h3F;
    idle(10);
    axi_rd(ADDR_STATUS, 32'h0, RESP_OKAY);
    chk_pin(exp_pins(3, 0, 0));
    // Shunt events in retry mode, then with the shunt check off
    for (int k = 0; k < 2; k++)
    begin
      axi_wr(ADDR_CTRL, (32'(MODE_RETRY) << CT_MODE) | (32'(k) << CT_SHUNT_OFF), RESP_OKAY);
      shunt_over <= 3'h2;
      idle(20);
      chk_pin((k != 0) ? exp_pins(3, 0, 0) : exp_pins(1, 0, 1));
      axi_rd(ADDR_STATUS, (k != 0) ? 32'h0 : SH_ST, RESP_OKAY);
      shunt_over <= 3'h0;
      idle(RETRY + 10);
      axi_rd(ADDR_STATUS, 32'h0, RESP_OKAY);
    end
    // Supply and gate rail undervoltage table
    for (int k = 0; k < 5; k++)
    begin
      axi_wr(ADDR_CTRL, 32'(k == 4) << CT_GATE_OFF, RESP_OKAY);
      uv <= UV_TAB[k];
      idle(10);
      chk_pin(PIN_TAB[k]);
      uv <= 4'h0;
      idle(10);
      chk_pin(8'hFF);
      axi_rd(ADDR_STATUS, ST_TAB[k], RESP_OKAY);
      en_pulse();
      axi_rd(ADDR_STATUS, 32'h0, RESP_OKAY);
    end
    test_done();
  end
endmodule : gdfp_top_tb_top
